// ### inc/atru_map.vh
// constants, register map and field layout of the address table read-back block
`ifndef ATRU_MAP_VH
`define ATRU_MAP_VH

// ======================================================
// register indexes on the plain register port
`define ATRU_ADDR_WB_LO 16'h1803
`define ATRU_ADDR_WB_UP 16'h1804
`define ATRU_ADDR_RB_LO 16'h1805
`define ATRU_ADDR_RB_UP 16'h1806
`define ATRU_ADDR_CMD 16'h1807
`define ATRU_ADDR_STS 16'h1808
`define ATRU_ADDR_GCFG 16'h180b

// ======================================================
// field positions
`define ATRU_UP_END 27
`define ATRU_UP_VALID 26
`define ATRU_UP_CTL_HI 25
`define ATRU_UP_CTL_LO 16
`define ATRU_UP_MAC_HI 15
`define ATRU_CTL_AGE1 9
`define ATRU_CTL_STATIC 8
`define ATRU_CTL_AGE0 7
`define ATRU_CTL_PEN 6
`define ATRU_CTL_PRIO_HI 5
`define ATRU_CTL_PRIO_LO 3
`define ATRU_CTL_PORT_HI 2
`define ATRU_CMD_FIRST 0
`define ATRU_CMD_NEXT 1
`define ATRU_CMD_MAKE 2
`define ATRU_STS_PEND 0
`define ATRU_STS_INIT 1
`define ATRU_GCFG_DPF 0

// ======================================================
// reset values and table geometry
`define ATRU_RST_WORD 32'h0000_0000
`define ATRU_RST_CTL 10'h000
`define ATRU_RST_MAC 48'h0000_0000_0000
`define ATRU_DEPTH 32
`define ATRU_IDX_W 5
`define ATRU_CUR_FIRST 6'h00
`define ATRU_CUR_LAST 6'h1f
`define ATRU_CUR_END 6'h20
`define ATRU_AGE_FULL 2'h3
`define ATRU_AGE_GONE 2'h0

// ======================================================
// timing: inactivity window in minutes, clock period in ns
`define ATRU_AGE_MIN_MIN 5
`define ATRU_AGE_MAX_MIN 10
`define ATRU_CLK_PERIOD_NS 5
`define ATRU_NS_PER_SEC 1000000000
`define ATRU_SEC_CYCLES (`ATRU_NS_PER_SEC / `ATRU_CLK_PERIOD_NS)
// four timer steps fit the longest window, three steps exceed the shortest
`define ATRU_AGE_TICK_SEC ((`ATRU_AGE_MAX_MIN * 60) / 4)

`endif

// ### logic/atru_tick.v
// aging tick generator: one pulse per aging timer step
`timescale 1ns/100ps
`include "atru_map.vh"
module atru_tick
#(
   parameter SEC_CYCLES = `ATRU_SEC_CYCLES
)
(
   // clock and reset
   input wire clk,
   input wire rstn,
   // tick out
   output reg age_tick
);

localparam [31:0] LAST_CYC = SEC_CYCLES - 1;
localparam [7:0] LAST_SEC = `ATRU_AGE_TICK_SEC - 1;

reg [31:0] cyc_cnt_r;
reg [7:0] sec_cnt_r;

// ======================================================
// second prescaler, then seconds per timer step
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      cyc_cnt_r <= 32'h0000_0000;
      sec_cnt_r <= 8'h00;
      age_tick <= 1'b0;
   end
   else
   begin
      age_tick <= 1'b0;
      if (cyc_cnt_r == LAST_CYC)
      begin
         cyc_cnt_r <= 32'h0000_0000;
         if (sec_cnt_r == LAST_SEC)
         begin
            sec_cnt_r <= 8'h00;
            age_tick <= 1'b1;
         end
         else
            sec_cnt_r <= sec_cnt_r + 8'h01;
      end
      else
         cyc_cnt_r <= cyc_cnt_r + 32'h0000_0001;
   end
end

endmodule // atru_tick

// ### logic/atru_fwd.v
// forwarding decision for a destination lookup against one table entry
`timescale 1ns/100ps
`include "atru_map.vh"
module atru_fwd
(
   // matched entry
   input wire hit,
   input wire [9:0] ctl,
   // port context
   input wire [1:0] src_port,
   input wire [2:0] port_disabled,
   input wire [2:0] port_blocked,
   input wire dst_prio_first,
   // decision
   output wire [2:0] fwd_ports,
   output wire drop,
   output wire prio_use
);

// port code to port mask; the reserved code selects nothing
function [2:0] port_mask;
   input [2:0] code;
   begin
      case (code)
         3'h0: port_mask = 3'h1;
         3'h1: port_mask = 3'h2;
         3'h2: port_mask = 3'h4;
         3'h4: port_mask = 3'h3;
         3'h5: port_mask = 3'h5;
         3'h6: port_mask = 3'h6;
         3'h7: port_mask = 3'h7;
         default: port_mask = 3'h0;
      endcase
   end
endfunction

wire is_static = ctl[`ATRU_CTL_STATIC];
wire override = hit & is_static & ctl[`ATRU_CTL_AGE1];
wire filter = hit & is_static & ctl[`ATRU_CTL_AGE0];
wire [2:0] src_mask = 3'h1 << src_port;
// a miss floods every port
wire [2:0] dest = hit ? port_mask(ctl[`ATRU_CTL_PORT_HI:0]) : 3'h7;
wire [2:0] allowed = override ? ~port_disabled : ~(port_disabled | port_blocked);
wire src_ok = |(src_mask & allowed);

// ======================================================
// egress set and discard
assign fwd_ports = (filter | ~src_ok) ? 3'h0 : (dest & allowed & ~src_mask);
assign drop = (fwd_ports == 3'h0);
assign prio_use = hit & ctl[`ATRU_CTL_PEN] & dst_prio_first;

endmodule // atru_fwd

// ### logic/atru_top.v
// address table with walk engine and read-back upper register
`timescale 1ns/100ps
`include "atru_map.vh"
module atru_top
#(
   parameter SEC_CYCLES = `ATRU_SEC_CYCLES
)
(
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // packet lookup request
   input wire lk_req,
   input wire [47:0] lk_da,
   input wire [47:0] lk_sa,
   input wire [1:0] lk_src_port,
   input wire [2:0] port_disabled,
   input wire [2:0] port_blocked,
   // packet lookup answer
   output reg lk_done,
   output reg lk_hit,
   output reg [2:0] lk_fwd_ports,
   output reg lk_drop,
   output reg lk_prio_use,
   output reg [2:0] lk_prio
);

// ======================================================
// engine states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_WALK = 3'b010;
localparam [2:0] ST_MAKE = 3'b100;

// table storage: control field laid out as upper register bits 25:16
reg [`ATRU_DEPTH-1:0] ent_vld_r;
reg [9:0] ent_ctl_r [0:`ATRU_DEPTH-1];
reg [47:0] ent_mac_r [0:`ATRU_DEPTH-1];

// read-back and software registers
reg rb_end_r;
reg rb_valid_r;
reg [9:0] rb_ctl_r;
reg [47:0] rb_mac_r;
reg [31:0] wb_lo_r;
reg [26:0] wb_up_r;
reg dpf_r;
reg pend_r;
reg init_r;
reg [2:0] state_r;
reg [5:0] cursor_r;

// search results
reg da_hit;
reg [`ATRU_IDX_W-1:0] da_idx;
reg sa_hit;
reg [`ATRU_IDX_W-1:0] sa_idx;
reg mk_ok;
reg [`ATRU_IDX_W-1:0] mk_idx;
reg mk_match;
reg [`ATRU_IDX_W-1:0] free_idx;
reg free_ok;
integer i;
integer k;

wire age_tick;
wire [2:0] fwd_ports;
wire fwd_drop;
wire fwd_prio_use;

// step an aging timer one count down
function [1:0] age_dec;
   input [9:0] ctl;
   begin
      age_dec = {ctl[`ATRU_CTL_AGE1], ctl[`ATRU_CTL_AGE0]} - 2'h1;
   end
endfunction

// ======================================================
// command decode; commands written while busy are dropped
wire idle = (state_r == ST_IDLE);
wire wr_cmd = reg_wr & (reg_addr == `ATRU_ADDR_CMD);
wire cmd_first = wr_cmd & reg_wdata[`ATRU_CMD_FIRST];
wire cmd_next = wr_cmd & reg_wdata[`ATRU_CMD_NEXT] & ~cmd_first;
wire cmd_walk = (cmd_first | cmd_next) & idle;
wire cmd_make = wr_cmd & reg_wdata[`ATRU_CMD_MAKE] & ~(cmd_first | cmd_next) & idle;
wire [5:0] cursor_nxt = cursor_r + 6'h01;
wire [`ATRU_IDX_W-1:0] cur_idx = cursor_r[`ATRU_IDX_W-1:0];
wire cur_in = (cursor_r != `ATRU_CUR_END);
wire [9:0] wb_ctl = wb_up_r[`ATRU_UP_CTL_HI:`ATRU_UP_CTL_LO];
wire [47:0] wb_mac = {wb_up_r[`ATRU_UP_MAC_HI:0], wb_lo_r};

// ======================================================
// parallel searches: destination, source and make-entry slot
always @*
begin
   da_hit = 1'b0;
   da_idx = {`ATRU_IDX_W{1'b0}};
   sa_hit = 1'b0;
   sa_idx = {`ATRU_IDX_W{1'b0}};
   mk_match = 1'b0;
   mk_idx = {`ATRU_IDX_W{1'b0}};
   free_ok = 1'b0;
   free_idx = {`ATRU_IDX_W{1'b0}};
   for (k = 0; k < `ATRU_DEPTH; k = k + 1)
   begin
      if (ent_vld_r[k] && ent_mac_r[k] == lk_da && !da_hit)
      begin
         da_hit = 1'b1;
         da_idx = k[`ATRU_IDX_W-1:0];
      end
      if (ent_vld_r[k] && ent_mac_r[k] == lk_sa && !sa_hit)
      begin
         sa_hit = 1'b1;
         sa_idx = k[`ATRU_IDX_W-1:0];
      end
      if (ent_vld_r[k] && ent_mac_r[k] == wb_mac && !mk_match)
      begin
         mk_match = 1'b1;
         mk_idx = k[`ATRU_IDX_W-1:0];
      end
      if (!ent_vld_r[k] && !free_ok)
      begin
         free_ok = 1'b1;
         free_idx = k[`ATRU_IDX_W-1:0];
      end
   end
   // an existing entry is overwritten in place, else a free slot is used
   mk_ok = mk_match | free_ok;
   if (!mk_match)
      mk_idx = free_idx;
end

// source refresh only for dynamic entries
wire sa_refresh = lk_req & sa_hit & ~ent_ctl_r[sa_idx][`ATRU_CTL_STATIC];
wire mk_do = (state_r == ST_MAKE) & mk_ok;

// ======================================================
// entry valid bits: aging removal and entry creation
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
      ent_vld_r <= {`ATRU_DEPTH{1'b0}};
   else
   begin
      if (age_tick)
      begin
         for (i = 0; i < `ATRU_DEPTH; i = i + 1)
         begin
            // static entries are never removed by aging
            if (ent_vld_r[i] && !ent_ctl_r[i][`ATRU_CTL_STATIC] &&
                {ent_ctl_r[i][`ATRU_CTL_AGE1], ent_ctl_r[i][`ATRU_CTL_AGE0]} == `ATRU_AGE_GONE &&
                !(sa_refresh && sa_idx == i[`ATRU_IDX_W-1:0]))
               ent_vld_r[i] <= 1'b0;
         end
      end
      if (mk_do)
         ent_vld_r[mk_idx] <= wb_up_r[`ATRU_UP_VALID];
   end
end

// ======================================================
// entry contents; plain memory, so no reset
always @(posedge clk)
begin
   if (age_tick)
   begin
      for (i = 0; i < `ATRU_DEPTH; i = i + 1)
      begin
         if (ent_vld_r[i] && !ent_ctl_r[i][`ATRU_CTL_STATIC] &&
             {ent_ctl_r[i][`ATRU_CTL_AGE1], ent_ctl_r[i][`ATRU_CTL_AGE0]} != `ATRU_AGE_GONE)
         begin
            {ent_ctl_r[i][`ATRU_CTL_AGE1], ent_ctl_r[i][`ATRU_CTL_AGE0]} <=
               age_dec(ent_ctl_r[i]);
         end
      end
   end
   // traffic from the source wins over the aging step
   if (sa_refresh)
   begin
      ent_ctl_r[sa_idx][`ATRU_CTL_AGE1] <= 1'b1;
      ent_ctl_r[sa_idx][`ATRU_CTL_AGE0] <= 1'b1;
   end
   if (mk_do)
   begin
      ent_ctl_r[mk_idx] <= wb_ctl;
      ent_mac_r[mk_idx] <= wb_mac;
   end
end

// ======================================================
// walk engine and read-back register
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      state_r <= ST_IDLE;
      cursor_r <= `ATRU_CUR_FIRST;
      rb_end_r <= 1'b0;
      rb_valid_r <= 1'b0;
      rb_ctl_r <= `ATRU_RST_CTL;
      rb_mac_r <= `ATRU_RST_MAC;
      pend_r <= 1'b0;
   end
   else
   begin
      case (state_r)
         ST_IDLE:
         begin
            if (cmd_walk)
            begin
               state_r <= ST_WALK;
               pend_r <= 1'b1;
               rb_valid_r <= 1'b0;
               rb_end_r <= 1'b0;
               if (cmd_first)
                  cursor_r <= `ATRU_CUR_FIRST;
            end
            else if (cmd_make)
            begin
               state_r <= ST_MAKE;
               pend_r <= 1'b1;
            end
         end
         ST_WALK:
         begin
            if (!cur_in)
            begin
               // walk already past the top: report the end again
               rb_end_r <= 1'b1;
               pend_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            else if (ent_vld_r[cur_idx])
            begin
               rb_valid_r <= 1'b1;
               rb_ctl_r <= ent_ctl_r[cur_idx];
               rb_mac_r <= ent_mac_r[cur_idx];
               rb_end_r <= (cursor_r == `ATRU_CUR_LAST);
               cursor_r <= cursor_nxt;
               pend_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            else
            begin
               // empty slot: valid stays clear, end flags the top
               cursor_r <= cursor_nxt;
               if (cursor_r == `ATRU_CUR_LAST)
               begin
                  rb_end_r <= 1'b1;
                  pend_r <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
         end
         ST_MAKE:
         begin
            pend_r <= 1'b0;
            state_r <= ST_IDLE;
         end
         default:
         begin
            state_r <= ST_IDLE;
            pend_r <= 1'b0;
         end
      endcase
   end
end

// ======================================================
// software registers; the read-back pair takes no writes
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      wb_lo_r <= `ATRU_RST_WORD;
      wb_up_r <= 27'h000_0000;
      dpf_r <= 1'b0;
      init_r <= 1'b0;
   end
   else
   begin
      init_r <= 1'b1; // table valid bits are cleared by reset
      if (reg_wr && reg_addr == `ATRU_ADDR_WB_LO)
         wb_lo_r <= reg_wdata;
      if (reg_wr && reg_addr == `ATRU_ADDR_WB_UP)
         wb_up_r <= reg_wdata[`ATRU_UP_VALID:0];
      if (reg_wr && reg_addr == `ATRU_ADDR_GCFG)
         dpf_r <= reg_wdata[`ATRU_GCFG_DPF];
   end
end

// ======================================================
// read data, one cycle after the read strobe, zero otherwise
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
      reg_rdata <= `ATRU_RST_WORD;
   else if (!reg_rd)
      reg_rdata <= `ATRU_RST_WORD;
   else
   begin
      case (reg_addr)
         `ATRU_ADDR_RB_LO: reg_rdata <= rb_mac_r[31:0];
         `ATRU_ADDR_RB_UP: reg_rdata <= {4'h0, rb_end_r, rb_valid_r, rb_ctl_r,
                                         rb_mac_r[47:32]};
         `ATRU_ADDR_WB_LO: reg_rdata <= wb_lo_r;
         `ATRU_ADDR_WB_UP: reg_rdata <= {5'h00, wb_up_r};
         `ATRU_ADDR_STS: reg_rdata <= {30'h0000_0000, init_r, pend_r};
         `ATRU_ADDR_GCFG: reg_rdata <= {31'h0000_0000, dpf_r};
         default: reg_rdata <= `ATRU_RST_WORD;
      endcase
   end
end

// ======================================================
// aging step generator and forwarding decision
atru_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick
(
   .clk(clk),
   .rstn(rstn),
   .age_tick(age_tick)
);

atru_fwd u_fwd
(
   .hit(da_hit),
   .ctl(ent_ctl_r[da_idx]),
   .src_port(lk_src_port),
   .port_disabled(port_disabled),
   .port_blocked(port_blocked),
   .dst_prio_first(dpf_r),
   .fwd_ports(fwd_ports),
   .drop(fwd_drop),
   .prio_use(fwd_prio_use)
);

// lookup answer registered one cycle after the request
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      lk_done <= 1'b0;
      lk_hit <= 1'b0;
      lk_fwd_ports <= 3'h0;
      lk_drop <= 1'b0;
      lk_prio_use <= 1'b0;
      lk_prio <= 3'h0;
   end
   else
   begin
      lk_done <= lk_req;
      lk_hit <= lk_req & da_hit;
      lk_fwd_ports <= lk_req ? fwd_ports : 3'h0;
      lk_drop <= lk_req & fwd_drop;
      lk_prio_use <= lk_req & fwd_prio_use;
      lk_prio <= (lk_req & fwd_prio_use) ?
                 ent_ctl_r[da_idx][`ATRU_CTL_PRIO_HI:`ATRU_CTL_PRIO_LO] : 3'h0;
   end
end

endmodule // atru_top

// ### bench/atru_top_checker.sv
// port-level assertion checker for the address table top
`timescale 1ns/100ps
`include "atru_map.vh"
module atru_top_checker
#(
   parameter SEC_CYCLES = 10
)
(
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // lookup
   input wire lk_req,
   input wire [47:0] lk_da,
   input wire [47:0] lk_sa,
   input wire [1:0] lk_src_port,
   input wire [2:0] port_disabled,
   input wire [2:0] port_blocked,
   input wire lk_done,
   input wire lk_hit,
   input wire [2:0] lk_fwd_ports,
   input wire lk_drop,
   input wire lk_prio_use,
   input wire [2:0] lk_prio
);
   reg dpf_r;
   reg [6:0] since_cmd_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // ======================================================
   // helpers
   // shadow of the global flag; command age saturates so a stale count never wraps
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dpf_r <= 1'b0;
         since_cmd_r <= 7'h7f;
      end
      else
      begin
         if (reg_wr && reg_addr == `ATRU_ADDR_GCFG)
            dpf_r <= reg_wdata[0];
         if (reg_wr && reg_addr == `ATRU_ADDR_CMD)
            since_cmd_r <= 7'h00;
         else if (since_cmd_r != 7'h7f)
            since_cmd_r <= since_cmd_r + 7'h01;
      end
   end

   // ======================================================
   // assertions
   AST_RB_RSVD: assert property (reg_rd && reg_addr == `ATRU_ADDR_RB_UP |=>
      reg_rdata[31:28] == 4'h0) else $error("reserved read-back bits not zero");
   AST_RD_STANDS: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   AST_LK_ANSWER: assert property (lk_req |=> lk_done)
      else $error("lookup not answered in one cycle");
   AST_LK_QUIET: assert property (!lk_req |=> !lk_done && lk_fwd_ports == 3'h0)
      else $error("lookup outputs without request");
   AST_DROP_EMPTY: assert property (lk_done |-> lk_drop == (lk_fwd_ports == 3'h0))
      else $error("drop flag disagrees with port mask");
   AST_DISABLED: assert property (lk_req |=> (lk_fwd_ports & $past(port_disabled)) == 3'h0)
      else $error("forwarded to disabled port");
   AST_PRIO_ZERO: assert property (lk_done && !lk_prio_use |-> lk_prio == 3'h0)
      else $error("priority given while unused");
   AST_PRIO_DPF: assert property (lk_prio_use |-> lk_hit && $past(dpf_r))
      else $error("priority used without hit and global flag");
   AST_PEND_CLR: assert property (reg_rd && reg_addr == `ATRU_ADDR_STS &&
      since_cmd_r >= 7'h28 |=> !reg_rdata[0]) else $error("pending stuck after command");

   // main scenarios
   COV_DROP: cover property (lk_done && lk_drop);
   COV_PRIO: cover property (lk_prio_use);
   COV_RB: cover property (reg_rd && reg_addr == `ATRU_ADDR_RB_UP ##1 reg_rdata[26]);
endmodule // atru_top_checker

bind atru_top atru_top_checker #(.SEC_CYCLES(SEC_CYCLES)) i_atru_top_checker (.clk(clk),
   .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .lk_req(lk_req), .lk_da(lk_da), .lk_sa(lk_sa),
   .lk_src_port(lk_src_port), .port_disabled(port_disabled), .port_blocked(port_blocked),
   .lk_done(lk_done), .lk_hit(lk_hit), .lk_fwd_ports(lk_fwd_ports), .lk_drop(lk_drop),
   .lk_prio_use(lk_prio_use), .lk_prio(lk_prio));

// ### bench/atru_top_tb.sv
// self-checking bench for the address table top
`timescale 1ns/100ps
`include "atru_map.vh"
module atru_top_tb;
   localparam SEC_CYCLES = 10;
   localparam TICK = SEC_CYCLES * `ATRU_AGE_TICK_SEC;
   localparam [47:0] MAC_A = 48'ha1b2_c3d4_e5f6;
   localparam [47:0] MAC_B = 48'h0011_2233_4455;
   localparam [47:0] MAC_C = 48'h0c0c_0c0c_0c0c;
   localparam [47:0] MAC_D = 48'h0d0d_0d0d_0d0d;
   reg clk;
   reg rstn;
   reg [15:0] reg_addr;
   reg [31:0] reg_wdata;
   reg reg_wr;
   reg reg_rd;
   wire [31:0] reg_rdata;
   reg lk_req;
   reg [47:0] lk_da;
   reg [47:0] lk_sa;
   reg [1:0] lk_src_port;
   reg [2:0] port_disabled;
   reg [2:0] port_blocked;
   wire lk_done;
   wire lk_hit;
   wire [2:0] lk_fwd_ports;
   wire lk_drop;
   wire lk_prio_use;
   wire [2:0] lk_prio;
   integer miscompares;
   integer samples_checked;
   integer i;
   reg [9:0] got;
   reg [2:0] m;

   atru_top #(.SEC_CYCLES(SEC_CYCLES)) i_atru_top (.clk(clk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .lk_req(lk_req), .lk_da(lk_da), .lk_sa(lk_sa),
      .lk_src_port(lk_src_port), .port_disabled(port_disabled), .port_blocked(port_blocked),
      .lk_done(lk_done), .lk_hit(lk_hit), .lk_fwd_ports(lk_fwd_ports), .lk_drop(lk_drop),
      .lk_prio_use(lk_prio_use), .lk_prio(lk_prio));

   // ======================================================
   // clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ======================================================
   // shared tasks
   task give_verdict;
   begin
      $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask

   task check(input [31:0] seen, input [31:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   end
   endtask

   task wr(input [15:0] a, input [31:0] d);
   begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   end
   endtask

   // data stands only in the cycle after the strobe, so sample just past that edge
   task rd(input [15:0] a, output [31:0] d);
   begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   end
   endtask

   task rd_chk(input [15:0] a, input [31:0] exp);
      reg [31:0] d;
   begin
      rd(a, d);
      check(d, exp);
   end
   endtask

   // bounded poll of one status bit; running out ends the run
   task wait_sts(input integer b, input v);
      integer n;
      reg [31:0] d;
   begin
      for (n = 0; n < 100; n = n + 1)
      begin
         rd(`ATRU_ADDR_STS, d);
         if (d[b] === v)
            n = 200;
      end
      if (n == 100)
      begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t: status wait ran out", $time);
         give_verdict;
      end
   end
   endtask

   task mk(input [47:0] mac, input [9:0] ctl);
   begin
      wr(`ATRU_ADDR_WB_LO, mac[31:0]);
      wr(`ATRU_ADDR_WB_UP, {5'h00, 1'b1, ctl, mac[47:32]});
      wr(`ATRU_ADDR_CMD, 32'h0000_0004);
      wait_sts(0, 1'b0);
   end
   endtask

   task lk(input [47:0] da, input [1:0] src, input [2:0] dis, input [2:0] blk);
   begin
      @(posedge clk);
      lk_req <= 1'b1;
      lk_da <= da;
      lk_src_port <= src;
      port_disabled <= dis;
      port_blocked <= blk;
      @(posedge clk);
      lk_req <= 1'b0;
      #1 got = {lk_done, lk_hit, lk_fwd_ports, lk_drop, lk_prio_use, lk_prio};
   end
   endtask

   // ======================================================
   // scenarios
   task t_walk;
   begin
      rd_chk(`ATRU_ADDR_RB_UP, 32'h0);
      rd_chk(16'h1900, 32'h0);
      mk(MAC_A, 10'h36d);
      mk(MAC_B, 10'h180);
      wr(`ATRU_ADDR_RB_UP, 32'hffff_ffff); // read-only place, must not stick
      rd_chk(`ATRU_ADDR_RB_UP, 32'h0);
      wr(`ATRU_ADDR_CMD, 32'h0000_0001);
      wait_sts(0, 1'b0);
      rd_chk(`ATRU_ADDR_RB_UP, {6'h01, 10'h36d, MAC_A[47:32]});
      rd_chk(`ATRU_ADDR_RB_LO, MAC_A[31:0]);
      wr(`ATRU_ADDR_CMD, 32'h0000_0002);
      wait_sts(0, 1'b0);
      rd_chk(`ATRU_ADDR_RB_UP, {6'h01, 10'h180, MAC_B[47:32]});
      wr(`ATRU_ADDR_CMD, 32'h0000_0002);
      rd_chk(`ATRU_ADDR_RB_UP, {6'h00, 10'h180, MAC_B[47:32]});
      wait_sts(0, 1'b0);
      rd_chk(`ATRU_ADDR_RB_UP, {6'h02, 10'h180, MAC_B[47:32]});
      $display("walk test done");
   end
   endtask

   task t_lookup;
   begin
      wr(`ATRU_ADDR_GCFG, 32'h1);
      lk(MAC_A, 2'h1, 3'h0, 3'h6);
      check(got, {2'h3, 3'h5, 2'h1, 3'h5});
      lk(MAC_A, 2'h1, 3'h4, 3'h6);
      check(got, {2'h3, 3'h1, 2'h1, 3'h5});
      lk(MAC_B, 2'h0, 3'h0, 3'h0);
      check(got, {2'h3, 3'h0, 2'h2, 3'h0});
      wr(`ATRU_ADDR_GCFG, 32'h0);
      lk(MAC_A, 2'h1, 3'h0, 3'h0);
      check(got, {2'h3, 3'h5, 2'h0, 3'h0});
      // every port code, seen from port 2 so the ingress bit is stripped
      for (i = 0; i < 8; i = i + 1)
      begin
         mk(MAC_C, 10'h100 | i[9:0]);
         case (i[2:0])
            3'h0: m = 3'h1;
            3'h1: m = 3'h2;
            3'h2: m = 3'h4;
            3'h3: m = 3'h0;
            3'h4: m = 3'h3;
            3'h5: m = 3'h5;
            3'h6: m = 3'h6;
            default: m = 3'h7;
         endcase
         m = m & 3'h3;
         lk(MAC_C, 2'h2, 3'h0, 3'h0);
         check(got, {2'h3, m, m == 3'h0, 4'h0});
      end
      $display("lookup test done");
   end
   endtask

   task t_age;
   begin
      mk(MAC_D, 10'h280);
      mk(MAC_C, 10'h280);
      lk(MAC_D, 2'h1, 3'h0, 3'h0);
      check(got, {2'h3, 3'h1, 5'h00});
      repeat (3 * TICK - 40) @(posedge clk);
      // traffic sourced from the second entry restarts its timer
      lk_sa <= MAC_C;
      lk(MAC_D, 2'h1, 3'h0, 3'h0);
      lk_sa <= 48'h0200_0000_0001;
      check(got, {2'h3, 3'h1, 5'h00});
      repeat (TICK + 80) @(posedge clk);
      lk(MAC_D, 2'h0, 3'h0, 3'h0);
      check(got, {2'h2, 3'h6, 5'h00});
      lk(MAC_A, 2'h0, 3'h0, 3'h0);
      check(got, {2'h3, 3'h4, 5'h00});
      lk(MAC_C, 2'h1, 3'h0, 3'h0);
      check(got, {2'h3, 3'h1, 5'h00});
      rd_chk(`ATRU_ADDR_STS, 32'h0000_0002);
      $display("aging test done");
   end
   endtask

   // ======================================================
   // main sequence
   initial
   begin
      miscompares = 0;
      samples_checked = 0;
      rstn = 1'b0;
      reg_addr = 16'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      lk_req = 1'b0;
      lk_da = 48'h0;
      lk_sa = 48'h0200_0000_0001;
      lk_src_port = 2'h0;
      port_disabled = 3'h0;
      port_blocked = 3'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      wait_sts(1, 1'b1);
      t_walk;
      t_lookup;
      t_age;
      give_verdict;
   end
endmodule // atru_top_tb
